// >>> inc/blm_pkg.sv
// Purpose: Shared constants and types for the gain, black level and mirror block
// Assumes: One 200 MHz clock; camera register addresses are full 32-bit byte addresses
// Notes:   Register bit 0 is the MSB, so field bit n sits at vector bit 31-n
package blm_pkg;
   // Register addresses
   localparam logic [31:0] BLACK_CTRL_ADDR = 32'hf0f00800;
   localparam logic [31:0] GAIN_CTRL_ADDR  = 32'hf0f00820;
   // Field positions, MSB-first numbering mapped to vector bits
   localparam int PRESENCE_BIT = 31;
   localparam int ABS_BIT      = 30;
   localparam int ONE_PUSH_BIT = 26;
   localparam int ON_BIT       = 25;
   localparam int AUTO_BIT     = 24;
   localparam int VALUE_MSB    = 11;
   // Limits: gain steps, black level in 1/64 LSB of an 8-bit scale (16 grey values)
   localparam logic [11:0] GAIN_MAX  = 12'h2a8;
   localparam logic [11:0] BLACK_MAX = 12'h400;
   // Values after reset
   localparam logic [11:0] GAIN_RESET  = 12'h000;
   localparam logic [11:0] BLACK_RESET = 12'h000;
   localparam logic        ON_RESET    = 1'b1;
   localparam logic        AUTO_RESET  = 1'b0;
   localparam logic        ABS_RESET   = 1'b0;
   // Duration of a single-shot adjustment
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ONE_PUSH_NS   = 100;
   localparam int ONE_PUSH_CYC  = (ONE_PUSH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] ONE_PUSH_LAST = 8'(ONE_PUSH_CYC - 1);

   typedef struct packed {
      logic        abs_ctl;
      logic        busy;
      logic        on;
      logic        auto_m;
      logic [11:0] value;
   } feat_s;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eol;
   } tag_s;
endpackage : blm_pkg

// >>> tb/blm_host.sv
// Purpose: Host model driving the camera register port
// Assumes: One access at a time, strobe taken at the edge after it rises
// Notes:   Released address and data show the inverse, never the last value
`timescale 1ns/1ps
`default_nettype none
module blm_host (
   // Clock
   input  wire logic        i_clk,
   // Register strobes towards the block
   output logic             o_wr,
   output logic             o_rd,
   output logic [31:0]      o_addr,
   output logic [31:0]      o_wdata
);
   initial
   begin
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_addr  = 32'h0;
      o_wdata = 32'h0;
   end

   // One strobe per access; the value field readback is trusted, the block supports it
   task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_wr    <= w;
      o_rd    <= !w;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_rd    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
   endtask : access
endmodule : blm_host
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the gain, black level and mirror block
// Assumes: Eight pixel lines, two lines a frame, eleven idle cycles between lines
// Notes:   Expected results queue up at the driver and are popped by the monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        I_CLK, I_RST, I_MIRROR, I_PIX_VALID, I_PIX_SOF, I_PIX_EOL;
   logic [11:0] I_ABS_BLACK, I_AUTO_BLACK, I_PIX_DATA, O_PIX_DATA;
   wire  logic  I_REG_WR, I_REG_RD;
   wire  logic [31:0] I_REG_ADDR, I_REG_WDATA;
   logic [31:0] O_REG_RDATA;
   logic        O_REG_ACK, O_PIX_VALID, O_PIX_SOF, O_PIX_EOL, O_BAYER_GRBG;
   logic [9:0]  O_GAIN;
   logic [31:0] rq[$];
   logic [13:0] pq[$];
   int          fail_count, comparisons, cycles, g;

   localparam logic [31:0] BL = blm_pkg::BLACK_CTRL_ADDR;
   localparam logic [31:0] GN = blm_pkg::GAIN_CTRL_ADDR;

   gain_black_level_mirror #(.PIX_W(12), .MAX_W(16)) DUT (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
      .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
      .O_REG_ACK(O_REG_ACK), .I_MIRROR(I_MIRROR), .I_ABS_BLACK(I_ABS_BLACK),
      .I_AUTO_BLACK(I_AUTO_BLACK), .I_PIX_VALID(I_PIX_VALID), .I_PIX_SOF(I_PIX_SOF),
      .I_PIX_EOL(I_PIX_EOL), .I_PIX_DATA(I_PIX_DATA), .O_PIX_VALID(O_PIX_VALID),
      .O_PIX_SOF(O_PIX_SOF), .O_PIX_EOL(O_PIX_EOL), .O_PIX_DATA(O_PIX_DATA),
      .O_BAYER_GRBG(O_BAYER_GRBG), .O_GAIN(O_GAIN));

   blm_host host (.i_clk(I_CLK), .o_wr(I_REG_WR), .o_rd(I_REG_RD),
      .o_addr(I_REG_ADDR), .o_wdata(I_REG_WDATA));

   initial
   begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end

   task automatic final_report;
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Writes answer with zero data, so every access leaves a note
   task automatic reg_op(input logic w, input logic [31:0] a, input logic [31:0] d,
                         input logic [31:0] exp);
      rq.push_back(exp);
      host.access(w, a, d);
   endtask : reg_op

   // Two lines; first pixel near full scale so the clamp is exercised
   task automatic frame(input logic mir, input int off);
      logic [11:0] px [8];
      int          e;
      @(posedge I_CLK);
      I_MIRROR <= mir;
      for (int l = 0; l < 2; l++)
      begin
         for (int k = 0; k < 8; k++)
            px[k] = (k == 0) ? 12'hffc : 12'($urandom);
         for (int k = 0; k < 8; k++)
         begin
            e = int'(px[mir ? 7 - k : k]) * 4 + off;
            e = (e > 16383 ? 16383 : e) >> 2;
            pq.push_back({l == 0 && k == 0, k == 7, 12'(e)});
         end
         for (int k = 0; k < 8; k++)
         begin
            @(posedge I_CLK);
            I_PIX_VALID <= 1'b1;
            I_PIX_SOF   <= (l == 0 && k == 0);
            I_PIX_EOL   <= (k == 7);
            I_PIX_DATA  <= px[k];
         end
         @(posedge I_CLK);
         I_PIX_VALID <= 1'b0;
         I_PIX_SOF   <= 1'b0;
         I_PIX_EOL   <= 1'b0;
         I_PIX_DATA  <= ~px[7];
         repeat (10) @(posedge I_CLK);
      end
      repeat (5) @(posedge I_CLK);
      chk("bayer_grbg", 32'(mir), 32'(O_BAYER_GRBG));
   endtask : frame

   always @(posedge I_CLK)
   begin
      if (O_REG_ACK === 1'b1)
         chk("reg_rdata", rq.size() > 0 ? rq.pop_front() : 'x, O_REG_RDATA);
      if (O_PIX_VALID === 1'b1)
         chk("pixel", pq.size() > 0 ? 32'(pq.pop_front()) : 'x,
             32'({O_PIX_SOF, O_PIX_EOL, O_PIX_DATA}));
   end

   // Whole run is a few hundred cycles
   always @(posedge I_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         final_report();
      end
   end

   initial
   begin
      void'($urandom(32'h4855));
      I_RST        = 1'b1;
      I_MIRROR     = 1'b0;
      I_PIX_VALID  = 1'b0;
      I_PIX_SOF    = 1'b0;
      I_PIX_EOL    = 1'b0;
      I_PIX_DATA   = 12'h000;
      I_ABS_BLACK  = 12'h400;
      I_AUTO_BLACK = 12'($urandom % 1025);
      repeat (16) @(posedge I_CLK);
      I_RST <= 1'b0;
      reg_op(1'b0, BL, 32'h0, 32'h8200_0000);
      reg_op(1'b0, GN, 32'h0, 32'h8200_0000);
      reg_op(1'b1, BL, 32'hba0f_f040, 32'h0);
      reg_op(1'b0, BL, 32'h0, 32'h8200_0040);
      reg_op(1'b1, BL, 32'h0200_0fff, 32'h0);
      reg_op(1'b0, BL, 32'h0, 32'h8200_0400);
      reg_op(1'b1, BL, 32'h0600_0040, 32'h0);
      reg_op(1'b0, BL, 32'h0, 32'h8600_0040);
      repeat (25) @(posedge I_CLK);
      reg_op(1'b0, BL, 32'h0, 32'h8200_0040);
      reg_op(1'b1, GN, 32'h0000_03ff, 32'h0);
      reg_op(1'b0, GN, 32'h0, 32'h8200_02a8);
      reg_op(1'b0, 32'hf0f0_0804, 32'h0, 32'h0);
      frame(1'b0, 64);
      chk("gain", 32'd680, 32'(O_GAIN));
      g = $urandom % 681;
      reg_op(1'b1, GN, 32'(g), 32'h0);
      reg_op(1'b0, GN, 32'h0, 32'h8200_0000 | 32'(g));
      chk("gain_hold", 32'd680, 32'(O_GAIN));
      frame(1'b1, 64);
      chk("gain", 32'(g), 32'(O_GAIN));
      reg_op(1'b1, BL, 32'h4200_0040, 32'h0);
      frame(1'b1, 1024);
      I_AUTO_BLACK <= 12'($urandom % 1025);
      reg_op(1'b1, BL, 32'h0300_0040, 32'h0);
      reg_op(1'b1, BL, 32'h0300_0123, 32'h0);
      reg_op(1'b0, BL, 32'h0, 32'h8300_0040);
      // Switchover frame is still checked, the block keeps it consistent
      frame(1'b0, int'(I_AUTO_BLACK));
      reg_op(1'b1, BL, 32'h0000_0040, 32'h0);
      reg_op(1'b1, BL, 32'h0000_0200, 32'h0);
      reg_op(1'b0, BL, 32'h0, 32'h8000_0040);
      frame(1'b1, 0);
      repeat (20) @(posedge I_CLK);
      chk("pending", 32'h0, 32'(pq.size() + rq.size()));
      final_report();
   end
endmodule : tb
`default_nettype wire

// >>> verilog/gain_black_level_mirror.sv
// Purpose: Gain setting, black level register and horizontal mirror on the pixel stream
// Assumes: Lines are no longer than MAX_W; line blanking is at least two cycles
// Notes:   Output lags the input by one line plus two cycles because of the line buffer
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Gain writable any time, range 0 to 680
// - Gain change leaves black offset unchanged
// - Black level from zero to 16 grey values; I_ABS_BLACK and I_AUTO_BLACK are passed on unclamped
// - Black level steps of 1/64 8-bit LSB
// - Black level register at 0xF0F00800
// - Bit 0 reads one: feature present
// - Bit 1 selects absolute value source
// - Bit 5 starts single shot, reads busy
// - Bit 6 switches feature on or off
// - Bit 7 selects manual or automatic mode
// - Value field ignores writes in auto/off
// - Mirror reverses pixel order within each line
// - Mirror axis is current field centre
// - Mirror combines with all other functions
// - Bayer order RGGB normal, GRBG mirrored
module gain_black_level_mirror #(
   parameter int PIX_W = 12,
   parameter int MAX_W = 2048
) (
   // Clock and reset
   input  wire  logic             I_CLK,
   input  wire  logic             I_RST,
   // Camera register port
   input  wire  logic             I_REG_WR,
   input  wire  logic             I_REG_RD,
   input  wire  logic [31:0]      I_REG_ADDR,
   input  wire  logic [31:0]      I_REG_WDATA,
   output logic       [31:0]      O_REG_RDATA,
   output logic                   O_REG_ACK,
   // Feature controls from neighbouring logic
   input  wire  logic             I_MIRROR,
   input  wire  logic [11:0]      I_ABS_BLACK,
   input  wire  logic [11:0]      I_AUTO_BLACK,
   // Pixels from the digitiser
   input  wire  logic             I_PIX_VALID,
   input  wire  logic             I_PIX_SOF,
   input  wire  logic             I_PIX_EOL,
   input  wire  logic [PIX_W-1:0] I_PIX_DATA,
   // Pixels to the formatter and gain to the analog front end
   output logic                   O_PIX_VALID,
   output logic                   O_PIX_SOF,
   output logic                   O_PIX_EOL,
   output logic       [PIX_W-1:0] O_PIX_DATA,
   output logic                   O_BAYER_GRBG,
   output logic       [9:0]       O_GAIN
);
   localparam int AW   = $clog2(MAX_W);
   localparam int FRAC = 14 - PIX_W;

   // Register state
   blm_pkg::feat_s     black;
   blm_pkg::feat_s     next_black;
   logic [11:0]        gain_csr;
   logic [11:0]        next_gain_csr;
   logic [7:0]         push_cnt;
   logic [7:0]         next_push_cnt;
   logic [31:0]        rdata;
   logic [31:0]        next_rdata;
   logic               ack;
   logic               next_ack;
   logic [9:0]         gain;
   logic [9:0]         next_gain;
   logic               wr_black;
   logic               wr_gain;
   logic [11:0]        wval;

   assign wr_black = I_REG_WR && (I_REG_ADDR == blm_pkg::BLACK_CTRL_ADDR);
   assign wr_gain  = I_REG_WR && (I_REG_ADDR == blm_pkg::GAIN_CTRL_ADDR);
   assign wval     = I_REG_WDATA[blm_pkg::VALUE_MSB:0];

   always_comb
   begin
      next_black    = black;
      next_gain_csr = gain_csr;
      next_push_cnt = push_cnt;
      next_rdata    = 32'h0000_0000;
      next_gain     = gain;
      if (wr_gain)
      begin
         next_gain_csr = (wval > blm_pkg::GAIN_MAX) ? blm_pkg::GAIN_MAX : wval;
      end
      if (black.busy)
      begin
         next_push_cnt = push_cnt + 8'h01;
         if (push_cnt == blm_pkg::ONE_PUSH_LAST)
         begin
            next_black.busy = 1'b0;
         end
      end
      if (wr_black)
      begin
         next_black.abs_ctl = I_REG_WDATA[blm_pkg::ABS_BIT];
         next_black.on      = I_REG_WDATA[blm_pkg::ON_BIT];
         next_black.auto_m  = I_REG_WDATA[blm_pkg::AUTO_BIT];
         if (black.on && !black.auto_m)
         begin
            next_black.value = (wval > blm_pkg::BLACK_MAX) ? blm_pkg::BLACK_MAX : wval;
         end
         // A start wins over the completion in the same cycle
         if (I_REG_WDATA[blm_pkg::ONE_PUSH_BIT])
         begin
            next_black.busy = 1'b1;
            next_push_cnt   = 8'h00;
         end
      end
      if (I_REG_RD && I_REG_ADDR == blm_pkg::BLACK_CTRL_ADDR)
      begin
         next_rdata[blm_pkg::PRESENCE_BIT]  = 1'b1;
         next_rdata[blm_pkg::ABS_BIT]       = black.abs_ctl;
         next_rdata[blm_pkg::ONE_PUSH_BIT]  = black.busy;
         next_rdata[blm_pkg::ON_BIT]        = black.on;
         next_rdata[blm_pkg::AUTO_BIT]      = black.auto_m;
         next_rdata[blm_pkg::VALUE_MSB:0]   = black.value;
      end
      else if (I_REG_RD && I_REG_ADDR == blm_pkg::GAIN_CTRL_ADDR)
      begin
         next_rdata[blm_pkg::PRESENCE_BIT]  = 1'b1;
         next_rdata[blm_pkg::ON_BIT]        = 1'b1;
         next_rdata[blm_pkg::VALUE_MSB:0]   = gain_csr;
      end
      next_ack = I_REG_RD || I_REG_WR;
      if (I_PIX_VALID && I_PIX_SOF)
      begin
         next_gain = gain_csr[9:0];
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         black    <= '{abs_ctl: blm_pkg::ABS_RESET, busy: 1'b0, on: blm_pkg::ON_RESET,
                       auto_m: blm_pkg::AUTO_RESET, value: blm_pkg::BLACK_RESET};
         gain_csr <= blm_pkg::GAIN_RESET;
         push_cnt <= 8'h00;
         rdata    <= 32'h0000_0000;
         ack      <= 1'b0;
         gain     <= blm_pkg::GAIN_RESET[9:0];
      end
      else
      begin
         black    <= next_black;
         gain_csr <= next_gain_csr;
         push_cnt <= next_push_cnt;
         rdata    <= next_rdata;
         ack      <= next_ack;
         gain     <= next_gain;
      end
   end

   assign O_REG_RDATA = rdata;
   assign O_REG_ACK   = ack;
   assign O_GAIN      = gain;

   // Line buffer: two banks, one fills while the other drains
   logic [PIX_W-1:0]   mem [2*MAX_W];
   logic               wbank, next_wbank;
   logic [AW:0]        wcnt, next_wcnt;
   logic               frame_mirror, next_frame_mirror;
   logic               line_sof, next_line_sof;
   logic               rbank, next_rbank;
   logic [AW:0]        rlen, next_rlen;
   logic [AW:0]        rcnt, next_rcnt;
   logic               rbusy, next_rbusy;
   logic               rsof, next_rsof;
   logic               rmirror, next_rmirror;
   logic               out_mirror, next_out_mirror;
   logic [11:0]        offset, next_offset;
   logic [AW:0]        ridx;
   logic [PIX_W-1:0]   rpix;
   blm_pkg::tag_s      tag1, next_tag1;
   logic [PIX_W-1:0]   opix, next_opix;
   blm_pkg::tag_s      otag;
   logic [PIX_W+FRAC:0] sum;

   // Reversing inside the stored line length mirrors about the current field centre
   assign ridx = rmirror ? (rlen - rcnt - (AW+1)'(1)) : rcnt;

   always_ff @(posedge I_CLK)
   begin
      if (I_PIX_VALID)
      begin
         mem[{wbank, wcnt[AW-1:0]}] <= I_PIX_DATA;
      end
      rpix <= mem[{rbank, ridx[AW-1:0]}];
   end

   always_comb
   begin
      next_wbank        = wbank;
      next_wcnt         = wcnt;
      next_frame_mirror = frame_mirror;
      next_line_sof     = line_sof;
      next_rbank        = rbank;
      next_rlen         = rlen;
      next_rcnt         = rcnt;
      next_rbusy        = rbusy;
      next_rsof         = rsof;
      next_rmirror      = rmirror;
      next_out_mirror   = out_mirror;
      next_offset       = offset;
      next_tag1         = '{valid: rbusy, sof: rbusy && rsof && rcnt == '0,
                            eol: rbusy && rcnt == rlen - (AW+1)'(1)};
      if (rbusy)
      begin
         next_rcnt = rcnt + (AW+1)'(1);
         if (rcnt == rlen - (AW+1)'(1))
         begin
            next_rbusy = 1'b0;
         end
      end
      if (I_PIX_VALID)
      begin
         next_wcnt = wcnt + (AW+1)'(1);
         if (I_PIX_SOF)
         begin
            next_frame_mirror = I_MIRROR;
            next_line_sof     = 1'b1;
         end
         if (I_PIX_EOL)
         begin
            next_wcnt     = '0;
            next_wbank    = !wbank;
            next_line_sof = 1'b0;
            next_rbank    = wbank;
            next_rlen     = wcnt + (AW+1)'(1);
            next_rcnt     = '0;
            next_rbusy    = 1'b1;
            next_rsof     = line_sof || I_PIX_SOF;
            next_rmirror  = I_PIX_SOF ? I_MIRROR : frame_mirror;
            if (line_sof || I_PIX_SOF)
            begin
               // Gain changes never touch the offset path
               next_offset     = !black.on ? 12'h000 :
                                 black.abs_ctl ? I_ABS_BLACK :
                                 black.auto_m ? I_AUTO_BLACK : black.value;
               next_out_mirror = I_PIX_SOF ? I_MIRROR : frame_mirror;
            end
         end
      end
      // Offset counts quarter steps below one output LSB, then saturates
      sum       = ({1'b0, rpix, FRAC'(0)}) + (PIX_W+FRAC+1)'(offset);
      next_opix = sum[PIX_W+FRAC] ? {PIX_W{1'b1}} : sum[PIX_W+FRAC-1:FRAC];
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         wbank        <= 1'b0;
         wcnt         <= '0;
         frame_mirror <= 1'b0;
         line_sof     <= 1'b0;
         rbank        <= 1'b0;
         rlen         <= '0;
         rcnt         <= '0;
         rbusy        <= 1'b0;
         rsof         <= 1'b0;
         rmirror      <= 1'b0;
         out_mirror   <= 1'b0;
         offset       <= 12'h000;
         tag1         <= '0;
         otag         <= '0;
         opix         <= '0;
      end
      else
      begin
         wbank        <= next_wbank;
         wcnt         <= next_wcnt;
         frame_mirror <= next_frame_mirror;
         line_sof     <= next_line_sof;
         rbank        <= next_rbank;
         rlen         <= next_rlen;
         rcnt         <= next_rcnt;
         rbusy        <= next_rbusy;
         rsof         <= next_rsof;
         rmirror      <= next_rmirror;
         out_mirror   <= next_out_mirror;
         offset       <= next_offset;
         tag1         <= next_tag1;
         otag         <= tag1;
         opix         <= next_opix;
      end
   end

   // Mirror sits before the offset stage and disables none of the stream stages
   assign O_PIX_VALID  = otag.valid;
   assign O_PIX_SOF    = otag.sof;
   assign O_PIX_EOL    = otag.eol;
   assign O_PIX_DATA   = opix;
   assign O_BAYER_GRBG = out_mirror;

   // Busy is seen low one cycle after the last count, hence the extra cycle
   localparam int PUSH_END = blm_pkg::ONE_PUSH_CYC + 1;

   sequence s_push_start;
      wr_black && I_REG_WDATA[blm_pkg::ONE_PUSH_BIT];
   endsequence
   sequence s_push_busy;
      black.busy [*2];
   endsequence

   a_push_busy_run: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_push_start |=> s_push_busy)
      else $error("single shot not busy after start");
   // A fresh start inside the window restarts the count and is legal
   a_push_ends: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_push_start |-> ##[1:PUSH_END]
      (!black.busy || (wr_black && I_REG_WDATA[blm_pkg::ONE_PUSH_BIT])))
      else $error("single shot never completes");
   a_presence_read: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_REG_RD && I_REG_ADDR == blm_pkg::BLACK_CTRL_ADDR |=> O_REG_RDATA[31] && O_REG_ACK)
      else $error("presence bit not set");
   a_reserved_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_REG_ACK |-> O_REG_RDATA[29:27] == 3'h0 && O_REG_RDATA[23:12] == 12'h000)
      else $error("reserved bits nonzero");
   a_value_locked: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_black && (black.auto_m || !black.on) |=> black.value == $past(black.value))
      else $error("value written in auto or off");
   a_black_limit: assert property (@(posedge I_CLK) disable iff (I_RST)
      black.value <= blm_pkg::BLACK_MAX)
      else $error("black level above limit");
   a_gain_limit: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_gain |=> gain_csr <= blm_pkg::GAIN_MAX && (($past(wval) > blm_pkg::GAIN_MAX) ?
      gain_csr == blm_pkg::GAIN_MAX : gain_csr == $past(wval)))
      else $error("gain write wrong");
   a_gain_keeps_black: assert property (@(posedge I_CLK) disable iff (I_RST)
      wr_gain && !wr_black |=> black == $past(black))
      else $error("gain write moved black level");
   a_gain_frame: assert property (@(posedge I_CLK) disable iff (I_RST)
      !(I_PIX_VALID && I_PIX_SOF) |=> O_GAIN == $past(O_GAIN))
      else $error("gain changed inside a frame");
   a_mirror_order: assert property (@(posedge I_CLK) disable iff (I_RST)
      rbusy && rmirror && rcnt == '0 |-> ridx == $past(wcnt))
      else $error("mirror does not start at line end");
endmodule : gain_black_level_mirror
`default_nettype wire
